/* rtl/dic_regs_top.sv */
/*
 Input configuration and status registers of a converter front end, with the
 sample FIFO, sync selection, error flags and sample path they steer.
 Assumes all pins synchronous to core_clk; the sample source writes one word
 per sample_valid and the converter reads one word per cycle once enabled.
*/
// Functional notes
// RULE1 - Format bit set, reset default, treats samples as two's complement.
// RULE2 - Format bit clear treats samples as offset binary.
// RULE3 - Software keeps format register reserved bits at their required values.
// RULE4 - Offset enable adds the working 13-bit offset into the sample path.
// RULE5 - Each set mask bit suppresses its matching error flag.
// RULE6 - Software sync bit may stand in for external sync and transmit enable.
// RULE7 - Sync source select uses only the software bit, ignoring external sync.
// RULE8 - Self-test failure sets its flag; writing zero clears it.
// RULE9 - With self test enabled, the self-test flag drives the serial output pin; four-pin reads put read data on that pin instead.
// RULE10 - FIFO pointer collision losing a sample sets the FIFO flag; zero clears.
// RULE11 - Unmasked checker flags any received word other than the checkerboard values.
// RULE12 - Source sends eight checkerboard words before software clears the pattern flag.
// RULE13 - Interface mode bit selects four-pin, else three-pin serial operation.
// RULE14 - Bus reverse bit swaps the incoming sample bit order.
// RULE15 - Clock divider sync disable blocks divider resync on sync events.
// RULE16 - FIFO sync disable blocks pointer offset reload on sync events.
// RULE17 - Delay-loop bypass captures data without clock skew adjustment.
// RULE18 - Software writes zero to reserved control and interface register bits.
// RULE19 - Each enabled sync event places input pointer by offset minus four to three.
// RULE20 - Working offset loads only on rising edge of the transfer bit.
// RULE21 - Error flags hold until software writes zero to them.
`timescale 1ns/100ps
`include "dic_cfg.svh"
module dic_regs_top #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic sden_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   input wire logic sample_valid,
   input wire logic [W-1:0] sample_in,
   input wire logic ext_sync_in,
   input wire logic [2:0] fifo_offset,
   input wire logic selftest_enable,
   input wire logic core_logic_self_check_fail,
   input wire logic [12:0] path_offset_value,
   input wire logic offset_transfer,
   output logic [W-1:0] dac_code,
   output logic dac_valid,
   output logic tx_enable,
   output logic clkdiv_sync,
   output logic dll_bypass,
   output logic four_pin_interface_mode
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0] fmt_ff;
   logic [7:0] oms_ff;
   logic [7:0] ibc_ff;
   logic st_flag_ff;
   logic ff_flag_ff;
   logic pt_flag_ff;
   logic sync_src_ff;
   logic xfer_ff;
   logic [12:0] work_off_ff;
   logic [AW-1:0] wr_ptr_ff;
   logic [AW-1:0] rd_ptr_ff;
   logic [W-1:0] mem_ff [DEPTH];
   logic [W-1:0] rd_word_ff;
   logic rd_valid_ff;
   logic clkdiv_sync_ff;
   logic [W-1:0] rev_word;
   logic sync_src;
   logic sync_evt;
   logic fifo_collide;
   logic pat_bad;
   logic err_wr;
   logic [4:0] rd_addr;
   logic [7:0] rd_data;
   logic [7:0] err_view;
   dic_pkg::dic_reg_wr_t reg_wr;
   dic_pkg::dic_path_cfg_t path_cfg;

   dic_serial_port u_serial (
      .core_clk(core_clk),
      .rstn(rstn),
      .sclk(sclk),
      .sden_n(sden_n),
      .sdio_in(sdio_in),
      .sdio_out(sdio_out),
      .sdio_oe(sdio_oe),
      .sdo_out(sdo_out),
      .sdo_oe(sdo_oe),
      .four_pin_interface_mode(four_pin_interface_mode),
      .selftest_enable(selftest_enable),
      .selftest_fail_flag(st_flag_ff),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .reg_wr(reg_wr)
   );

   // Configuration registers hold what software wrote, reserved bits included.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fmt_ff <= `DIC_RST_FMT;
         oms_ff <= `DIC_RST_OMS;
         ibc_ff <= `DIC_RST_IBC;
      end else if (reg_wr.wr) begin
         if (reg_wr.addr == `DIC_ADDR_FMT) begin
            fmt_ff <= reg_wr.data;
         end
         if (reg_wr.addr == `DIC_ADDR_OMS) begin
            oms_ff <= reg_wr.data;
         end
         if (reg_wr.addr == `DIC_ADDR_IBC) begin
            ibc_ff <= reg_wr.data;
         end
      end
   end

   assign four_pin_interface_mode = ibc_ff[`DIC_IBC_FOUR_PIN_INTERFACE_MODE]; // RULE13
   assign dll_bypass = ibc_ff[`DIC_IBC_BYP]; // RULE17

   assign err_view = {1'b0, st_flag_ff, ff_flag_ff, pt_flag_ff, 4'h0};

   always_comb begin
      unique case (rd_addr)
         `DIC_ADDR_FMT: rd_data = fmt_ff;
         `DIC_ADDR_OMS: rd_data = oms_ff;
         `DIC_ADDR_ERR: rd_data = err_view;
         `DIC_ADDR_IBC: rd_data = ibc_ff;
         default: rd_data = 8'h00;
      endcase
   end

   // Sync selection: the register bit replaces the external pin when selected.
   assign sync_src = oms_ff[`DIC_OMS_SWSEL] ? oms_ff[`DIC_OMS_SWSYNC] : ext_sync_in; // RULE6 RULE7
   assign sync_evt = sync_src & ~sync_src_ff;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync_src_ff <= 1'b0;
         clkdiv_sync_ff <= 1'b0;
      end else begin
         sync_src_ff <= sync_src;
         clkdiv_sync_ff <= sync_evt & ~ibc_ff[`DIC_IBC_CKDIS]; // RULE15
      end
   end

   assign tx_enable = sync_src_ff; // RULE6
   assign clkdiv_sync = clkdiv_sync_ff;

   // Input bus bit reversal ahead of the FIFO and the pattern checker.
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_rev
         assign rev_word[gi] = ibc_ff[`DIC_IBC_REV] ? sample_in[W-1-gi] : sample_in[gi]; // RULE14
      end
   endgenerate

   // A write landing on the slot being read in the same cycle loses a sample.
   assign fifo_collide = sample_valid & tx_enable & (wr_ptr_ff == rd_ptr_ff); // RULE10

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_ff <= '0;
      end else if (sync_evt && !ibc_ff[`DIC_IBC_FFDIS]) begin
         wr_ptr_ff <= AW'(rd_ptr_ff + AW'(DEPTH / 2) + AW'($signed(fifo_offset))); // RULE19 RULE16
      end else if (sample_valid) begin
         wr_ptr_ff <= AW'(wr_ptr_ff + AW'(1));
      end
   end

   // Slots are cleared so that a read ahead of the first write gives a known code.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_ff[i] <= '0;
         end
      end else if (sample_valid) begin
         mem_ff[wr_ptr_ff] <= rev_word;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_ptr_ff <= '0;
         rd_word_ff <= '0;
         rd_valid_ff <= 1'b0;
      end else begin
         rd_valid_ff <= tx_enable;
         if (tx_enable) begin
            rd_word_ff <= mem_ff[rd_ptr_ff];
            rd_ptr_ff <= AW'(rd_ptr_ff + AW'(1));
         end
      end
   end

   assign pat_bad = sample_valid & (rev_word != W'(`DIC_PAT_A))
      & (rev_word != W'(`DIC_PAT_B)); // RULE11

   // Error flags: set beats a write of zero in the same cycle.
   assign err_wr = reg_wr.wr & (reg_wr.addr == `DIC_ADDR_ERR);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_flag_ff <= 1'b0;
         ff_flag_ff <= 1'b0;
         pt_flag_ff <= 1'b0;
      end else begin
         st_flag_ff <= (core_logic_self_check_fail & ~oms_ff[`DIC_OMS_STMASK]) // RULE8 RULE5
            | (st_flag_ff & ~(err_wr & ~reg_wr.data[`DIC_ERR_ST])); // RULE21
         ff_flag_ff <= (fifo_collide & ~oms_ff[`DIC_OMS_FFMASK]) // RULE10 RULE5
            | (ff_flag_ff & ~(err_wr & ~reg_wr.data[`DIC_ERR_FF])); // RULE21
         pt_flag_ff <= (pat_bad & ~oms_ff[`DIC_OMS_PTMASK]) // RULE11 RULE5
            | (pt_flag_ff & ~(err_wr & ~reg_wr.data[`DIC_ERR_PT])); // RULE21
      end
   end

   // Working offset is double buffered behind the transfer bit.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         xfer_ff <= 1'b0;
         work_off_ff <= 13'h0000;
      end else begin
         xfer_ff <= offset_transfer;
         if (offset_transfer && !xfer_ff) begin
            work_off_ff <= path_offset_value; // RULE20
         end
      end
   end

   assign path_cfg.twos_comp = fmt_ff[`DIC_FMT_TWOS]; // RULE1 RULE2
   assign path_cfg.offset_en = oms_ff[`DIC_OMS_OFFEN]; // RULE4
   assign path_cfg.offset = work_off_ff;

   dic_sample_path #(
      .W(W)
   ) u_path (
      .core_clk(core_clk),
      .rstn(rstn),
      .word_valid(rd_valid_ff),
      .word(rd_word_ff),
      .cfg(path_cfg),
      .dac_code(dac_code),
      .dac_valid(dac_valid)
   );

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_mask_holds_flag: assert property ( // RULE5
      oms_ff[`DIC_OMS_PTMASK] && !pt_flag_ff |=> !pt_flag_ff)
      else $error("masked pattern flag became set");
   chk_sel_ignores_pin: assert property ( // RULE7
      oms_ff[`DIC_OMS_SWSEL] && !oms_ff[`DIC_OMS_SWSYNC] |=> !tx_enable)
      else $error("external sync used while software source selected");
   chk_selftest_set: assert property ( // RULE8
      core_logic_self_check_fail && !oms_ff[`DIC_OMS_STMASK] |=> st_flag_ff)
      else $error("self-test failure not flagged");
   chk_flag_clear: assert property ( // RULE8
      err_wr && !reg_wr.data[`DIC_ERR_ST] && !core_logic_self_check_fail |=> !st_flag_ff)
      else $error("self-test flag not cleared by zero write");
   chk_fifo_overrun: assert property ( // RULE10
      fifo_collide && !oms_ff[`DIC_OMS_FFMASK] |=> ff_flag_ff [*2] or (ff_flag_ff ##1 1'b1))
      else $error("fifo collision not flagged");
   chk_pattern_flag: assert property ( // RULE11
      sample_valid && !oms_ff[`DIC_OMS_PTMASK] && rev_word != W'(`DIC_PAT_A)
      && rev_word != W'(`DIC_PAT_B) |=> pt_flag_ff)
      else $error("bad pattern word not flagged");
   chk_reverse_bus: assert property ( // RULE14
      sample_valid && ibc_ff[`DIC_IBC_REV] |-> rev_word[0] == sample_in[W-1])
      else $error("bus not reversed");
   chk_ckdiv_blocked: assert property ( // RULE15
      sync_evt && ibc_ff[`DIC_IBC_CKDIS] |=> !clkdiv_sync)
      else $error("clock divider resynced while disabled");
   chk_fifo_sync_off: assert property ( // RULE16
      sync_evt && ibc_ff[`DIC_IBC_FFDIS] && !sample_valid |=> $stable(wr_ptr_ff))
      else $error("fifo pointer reloaded while disabled");
   chk_ptr_reload: assert property ( // RULE19
      sync_evt && !ibc_ff[`DIC_IBC_FFDIS] |=> wr_ptr_ff == AW'($past(rd_ptr_ff)
      + AW'(DEPTH / 2) + AW'($signed($past(fifo_offset)))))
      else $error("fifo pointer offset not applied");
   chk_offset_load: assert property ( // RULE20
      !($rose(offset_transfer)) |=> $stable(work_off_ff))
      else $error("working offset changed without transfer edge");
   chk_flag_sticky: assert property ( // RULE21
      ff_flag_ff && !err_wr |=> ff_flag_ff)
      else $error("fifo flag dropped without clear");

   cov_sync_event: cover property (sync_evt ##1 tx_enable [*3]);
   cov_pattern_err: cover property (!pt_flag_ff ##1 pt_flag_ff);
   cov_offset_load: cover property ($rose(offset_transfer) ##1 oms_ff[`DIC_OMS_OFFEN]);
endmodule // dic_regs_top

/* pkg/dic_cfg.svh */
/*
 Register offsets, reset values, field positions and fixed data words of the
 converter input configuration block. Included by every rtl file and by the test bench, not by the package.
*/
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH

`define DIC_ADDR_FMT 5'h02
`define DIC_ADDR_OMS 5'h03
`define DIC_ADDR_ERR 5'h04
`define DIC_ADDR_IBC 5'h05

`define DIC_RST_FMT 8'hC0
`define DIC_RST_OMS 8'h70
`define DIC_RST_ERR 8'h00
`define DIC_RST_IBC 8'h00

`define DIC_FMT_TWOS 7
`define DIC_OMS_OFFEN 7
`define DIC_OMS_STMASK 6
`define DIC_OMS_FFMASK 5
`define DIC_OMS_PTMASK 4
`define DIC_OMS_SWSYNC 1
`define DIC_OMS_SWSEL 0
`define DIC_ERR_ST 6
`define DIC_ERR_FF 5
`define DIC_ERR_PT 4
`define DIC_IBC_FOUR_PIN_INTERFACE_MODE 7
`define DIC_IBC_REV 6
`define DIC_IBC_CKDIS 5
`define DIC_IBC_FFDIS 4
`define DIC_IBC_BYP 2

`define DIC_PAT_A 16'hAAAA
`define DIC_PAT_B 16'h5555
`define DIC_SIGN_FLIP 16'h8000

`define DIC_SPI_RW 7
`define DIC_SPI_INSTR_LAST 4'h7
`define DIC_SPI_DATA_FIRST 4'h8
`define DIC_SPI_LAST 4'hF

`endif

/* pkg/dic_pkg.sv */
/*
 Types shared by the converter input configuration block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package dic_pkg;
   typedef enum logic [2:0] {
      DIC_SPI_IDLE = 3'b001,
      DIC_SPI_INSTR = 3'b010,
      DIC_SPI_DATA = 3'b100
   } dic_spi_state_t;

   typedef struct packed {
      logic twos_comp;
      logic offset_en;
      logic [12:0] offset;
   } dic_path_cfg_t;

   typedef struct packed {
      logic wr;
      logic [4:0] addr;
      logic [7:0] data;
   } dic_reg_wr_t;
endpackage

/* rtl/dic_serial_port.sv */
/*
 Serial control port: 16-bit frames of instruction byte then data byte.
 Assumes serial pins synchronous to core_clk and slower than half its rate.
*/
`timescale 1ns/100ps
`include "dic_cfg.svh"
module dic_serial_port (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sclk,
   input wire logic sden_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic sdo_out,
   output logic sdo_oe,
   input wire logic four_pin_interface_mode,
   input wire logic selftest_enable,
   input wire logic selftest_fail_flag,
   output logic [4:0] rd_addr,
   input wire logic [7:0] rd_data,
   output dic_pkg::dic_reg_wr_t reg_wr
);
   dic_pkg::dic_spi_state_t state_ff;
   logic sclk_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] instr_ff;
   logic [7:0] tx_ff;
   logic rise;
   logic fall;
   logic reading;

   assign rise = sclk & ~sclk_ff;
   assign fall = ~sclk & sclk_ff;
   assign rd_addr = {shift_ff[3:0], sdio_in};
   assign reading = (state_ff == dic_pkg::DIC_SPI_DATA) & instr_ff[`DIC_SPI_RW];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sclk_ff <= 1'b0;
      end else begin
         sclk_ff <= sclk;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= dic_pkg::DIC_SPI_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         instr_ff <= 8'h00;
      end else if (sden_n) begin
         state_ff <= dic_pkg::DIC_SPI_IDLE;
         cnt_ff <= 4'h0;
      end else begin
         unique case (state_ff)
            dic_pkg::DIC_SPI_IDLE: begin
               state_ff <= dic_pkg::DIC_SPI_INSTR;
            end
            dic_pkg::DIC_SPI_INSTR: begin
               if (rise) begin
                  shift_ff <= {shift_ff[6:0], sdio_in};
                  cnt_ff <= cnt_ff + 4'h1;
                  if (cnt_ff == `DIC_SPI_INSTR_LAST) begin
                     instr_ff <= {shift_ff[6:0], sdio_in};
                     state_ff <= dic_pkg::DIC_SPI_DATA;
                  end
               end
            end
            dic_pkg::DIC_SPI_DATA: begin
               if (rise) begin
                  shift_ff <= {shift_ff[6:0], sdio_in};
                  cnt_ff <= cnt_ff + 4'h1;
                  if (cnt_ff == `DIC_SPI_LAST) begin
                     state_ff <= dic_pkg::DIC_SPI_INSTR;
                  end
               end
            end
         endcase
      end
   end

   // Read data is loaded when the instruction completes and shifted on falling edges.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         tx_ff <= 8'h00;
      end else if (state_ff == dic_pkg::DIC_SPI_INSTR && rise && cnt_ff == `DIC_SPI_INSTR_LAST) begin
         tx_ff <= rd_data;
      end else if (state_ff == dic_pkg::DIC_SPI_DATA && fall && cnt_ff != `DIC_SPI_DATA_FIRST) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         reg_wr <= '0;
      end else begin
         reg_wr.wr <= ~sden_n & rise & (state_ff == dic_pkg::DIC_SPI_DATA)
            & (cnt_ff == `DIC_SPI_LAST) & ~instr_ff[`DIC_SPI_RW];
         reg_wr.addr <= instr_ff[4:0];
         reg_wr.data <= {shift_ff[6:0], sdio_in};
      end
   end

   assign sdio_out = tx_ff[7];
   assign sdio_oe = reading & ~four_pin_interface_mode; // RULE13
   assign sdo_oe = (reading & four_pin_interface_mode) | selftest_enable; // RULE13
   assign sdo_out = (reading & four_pin_interface_mode) ? tx_ff[7] : selftest_fail_flag; // RULE9

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_sdo_selftest: assert property ( // RULE9
      selftest_enable && !reading |-> sdo_oe && sdo_out == selftest_fail_flag)
      else $error("self-test flag not on sdo");
   chk_pin_mode: assert property ( // RULE13
      reading |-> (sdio_oe != four_pin_interface_mode))
      else $error("read data on wrong pin for interface mode");
   cov_write: cover property (reg_wr.wr);
endmodule // dic_serial_port

/* rtl/dic_sample_path.sv */
/*
 Sample path: input format conversion and system offset addition.
 Output is an offset-binary code; assumes cfg is steady while samples flow.
*/
`timescale 1ns/100ps
`include "dic_cfg.svh"
module dic_sample_path #(
   parameter int W = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic word_valid,
   input wire logic [W-1:0] word,
   input wire dic_pkg::dic_path_cfg_t cfg,
   output logic [W-1:0] dac_code,
   output logic dac_valid
);
   logic [W-1:0] s_word;
   logic [W-1:0] add_val;
   logic [W-1:0] nxt_code;

   assign s_word = cfg.twos_comp ? word : (word ^ W'(`DIC_SIGN_FLIP)); // RULE1 RULE2
   assign add_val = cfg.offset_en ? W'($signed(cfg.offset)) : '0; // RULE4
   assign nxt_code = W'(s_word + add_val) ^ W'(`DIC_SIGN_FLIP);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         dac_code <= '0;
         dac_valid <= 1'b0;
      end else begin
         dac_valid <= word_valid;
         if (word_valid) begin
            dac_code <= nxt_code;
         end
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);

   chk_twos_format: assert property ( // RULE1
      word_valid && cfg.twos_comp && !cfg.offset_en
      |=> dac_code == ($past(word) ^ W'(`DIC_SIGN_FLIP)))
      else $error("two's complement sample converted wrongly");
   chk_binary_format: assert property ( // RULE2
      word_valid && !cfg.twos_comp && !cfg.offset_en |=> dac_code == $past(word))
      else $error("offset binary sample converted wrongly");
   chk_offset_sum: assert property ( // RULE4
      word_valid && cfg.twos_comp && cfg.offset_en |=> dac_code == W'(($past(word)
      + W'($signed($past(cfg.offset)))) ^ W'(`DIC_SIGN_FLIP)))
      else $error("offset not summed into sample");
endmodule // dic_sample_path

/* tb/dic_host_model.sv */
/*
 Serial host model: issues 16-bit instruction and data frames, samples read data.
 Assumes core_clk paces the frames and the bench resolves the shared data wire.
*/
`timescale 1ns/100ps
module dic_host_model (
   input wire logic core_clk,
   input wire logic four_pin,
   input wire logic sdio_out,
   input wire logic sdo_out,
   output logic sclk,
   output logic sden_n,
   output logic sdio
);
   initial begin
      sclk = 1'b0;
      sden_n = 1'b1;
      sdio = 1'b1;
   end

   // Each sclk half period lasts two core clocks; data changes while sclk is low.
   task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
      @(posedge core_clk);
      sden_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         sdio <= frame[i];
         repeat (2) @(posedge core_clk);
         if (i < 8) begin
            rd[i] = four_pin ? sdo_out : sdio_out;
         end
         sclk <= 1'b1;
         repeat (2) @(posedge core_clk);
         sclk <= 1'b0;
      end
      sden_n <= 1'b1;
      // A released line must not keep showing the last bit.
      sdio <= ~sdio;
      repeat (3) @(posedge core_clk);
   endtask
endmodule // dic_host_model

/* tb/test_dic_regs_top.sv */
/*
 Self-checking bench of the input configuration registers and sample path.
 Assumes the serial host model and the design files are compiled beforehand.
*/
`timescale 1ns/100ps
`include "dic_cfg.svh"
module test_dic_regs_top;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic sclk, sden_n, host_sdio, sdio_out, sdio_oe, sdo_out, sdo_oe;
   logic sample_valid = 1'b0;
   logic [15:0] sample_in = 16'h0000;
   logic ext_sync_in = 1'b0;
   logic [2:0] fifo_offset = 3'h0;
   logic selftest_enable = 1'b0;
   logic st_fail = 1'b0;
   logic [12:0] path_offset_value = 13'h0000;
   logic offset_transfer = 1'b0;
   logic [15:0] dac_code;
   logic dac_valid, tx_enable, clkdiv_sync, dll_bypass, four_pin;
   logic [7:0] rd;
   int n_errors = 0;
   int num_checks = 0;
   int n_div = 0;
   wire sdio_wire = sdio_oe ? sdio_out : host_sdio;

   always #4 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      if (clkdiv_sync === 1'b1) begin
         n_div <= n_div + 1;
      end
   end

   dic_host_model host (.core_clk(core_clk), .four_pin(four_pin), .sdio_out(sdio_wire),
      .sdo_out(sdo_out), .sclk(sclk), .sden_n(sden_n), .sdio(host_sdio));

   dic_regs_top #(.W(16), .DEPTH(8)) dut (.core_clk(core_clk), .rstn(rstn), .sclk(sclk),
      .sden_n(sden_n), .sdio_in(sdio_wire), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_valid(sample_valid),
      .sample_in(sample_in), .ext_sync_in(ext_sync_in), .fifo_offset(fifo_offset),
      .selftest_enable(selftest_enable), .core_logic_self_check_fail(st_fail),
      .path_offset_value(path_offset_value), .offset_transfer(offset_transfer),
      .dac_code(dac_code), .dac_valid(dac_valid), .tx_enable(tx_enable),
      .clkdiv_sync(clkdiv_sync), .dll_bypass(dll_bypass),
      .four_pin_interface_mode(four_pin));

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({3'b000, a, d}, rd);
   endtask

   task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
      host.xfer({3'b100, a, 8'h00}, rd);
      check("register", {8'h00, exp}, {8'h00, rd});
   endtask

   // A gap of one sends a word every other cycle so the reader overtakes the writer.
   task automatic stream(input logic [15:0] w, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         sample_in <= w;
         sample_valid <= (gap == 0) || (i % 2 == 0);
         @(posedge core_clk);
      end
      sample_valid <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask

   // Raises one event input for four cycles: 0 external sync, 1 offset transfer, else self-test fail.
   task automatic pulse(input int sel);
      for (int lvl = 1; lvl >= 0; lvl--) begin
         case (sel)
            0: ext_sync_in <= lvl[0];
            1: offset_transfer <= lvl[0];
            default: st_fail <= lvl[0];
         endcase
         repeat (4) @(posedge core_clk);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d, errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      rchk(`DIC_ADDR_FMT, 8'hC0);
      rchk(`DIC_ADDR_OMS, 8'h70);
      rchk(`DIC_ADDR_ERR, 8'h00);
      rchk(`DIC_ADDR_IBC, 8'h00);
      wr(5'h10, 8'h5A);
      rchk(5'h10, 8'h00);
      wr(`DIC_ADDR_IBC, 8'h84);
      check("four_pin", 16'h1, {15'h0, four_pin});
      check("dll_bypass", 16'h1, {15'h0, dll_bypass});
      rchk(`DIC_ADDR_IBC, 8'h84);
      wr(`DIC_ADDR_IBC, 8'h00);
      check("four_pin", 16'h0, {15'h0, four_pin});
      ext_sync_in <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("tx_enable", 16'h1, {15'h0, tx_enable});
      ext_sync_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      check("divider syncs", 16'h1, 16'(n_div));
      wr(`DIC_ADDR_OMS, 8'h21);
      pulse(0);
      check("tx_enable", 16'h0, {15'h0, tx_enable});
      check("divider syncs", 16'h1, 16'(n_div));
      fifo_offset <= 3'h5;
      wr(`DIC_ADDR_IBC, 8'h30);
      wr(`DIC_ADDR_OMS, 8'h23);
      check("tx_enable", 16'h1, {15'h0, tx_enable});
      check("divider syncs", 16'h1, 16'(n_div));
      wr(`DIC_ADDR_OMS, 8'h21);
      wr(`DIC_ADDR_IBC, 8'h00);
      wr(`DIC_ADDR_OMS, 8'h23);
      check("divider syncs", 16'h2, 16'(n_div));
      stream(16'h1234, 16, 0);
      check("dac_code", 16'h9234, dac_code);
      check("dac_valid", 16'h1, {15'h0, dac_valid});
      rchk(`DIC_ADDR_ERR, 8'h10);
      stream(16'hAAAA, 8, 0);
      stream(16'h5555, 8, 0);
      rchk(`DIC_ADDR_ERR, 8'h10);
      check("dac_code", 16'hD555, dac_code);
      wr(`DIC_ADDR_ERR, 8'h00);
      rchk(`DIC_ADDR_ERR, 8'h00);
      wr(`DIC_ADDR_FMT, 8'h40);
      stream(16'h1234, 16, 0);
      check("dac_code", 16'h1234, dac_code);
      path_offset_value <= 13'h0010;
      pulse(1);
      wr(`DIC_ADDR_OMS, 8'hA3);
      wr(`DIC_ADDR_FMT, 8'hC0);
      stream(16'h1234, 16, 0);
      check("dac_code", 16'h9244, dac_code);
      path_offset_value <= 13'h0020;
      stream(16'h1234, 16, 0);
      check("dac_code", 16'h9244, dac_code);
      pulse(1);
      stream(16'h1234, 16, 0);
      check("dac_code", 16'h9254, dac_code);
      wr(`DIC_ADDR_OMS, 8'h23);
      wr(`DIC_ADDR_IBC, 8'h40);
      wr(`DIC_ADDR_FMT, 8'h40);
      stream(16'h0003, 16, 0);
      check("dac_code", 16'hC000, dac_code);
      wr(`DIC_ADDR_IBC, 8'h00);
      selftest_enable <= 1'b1;
      pulse(2);
      check("sdo_oe", 16'h1, {15'h0, sdo_oe});
      check("sdo_out", 16'h1, {15'h0, sdo_out});
      rchk(`DIC_ADDR_ERR, 8'h50);
      wr(`DIC_ADDR_ERR, 8'h10);
      rchk(`DIC_ADDR_ERR, 8'h10);
      check("sdo_out", 16'h0, {15'h0, sdo_out});
      wr(`DIC_ADDR_OMS, 8'h63);
      pulse(2);
      rchk(`DIC_ADDR_ERR, 8'h10);
      wr(`DIC_ADDR_OMS, 8'h03);
      stream(16'h5555, 24, 1);
      rchk(`DIC_ADDR_ERR, 8'h30);
      summarize();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      summarize();
   end
endmodule // test_dic_regs_top
